//--- src/aafc_frontend.sv
`include "aafc_params.svh"

module aafc_frontend
   import aafc_pkg::*;
#(
   parameter int unsigned IDAC_START_CYCLES = `AAFC_IDAC_START_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_code,
   input  wire logic [13:0] temp_code,
   output logic             conv_start,
   output logic             conv_active,
   output logic      [3:0]  input_select,
   output logic      [2:0]  gain_sel,
   output logic             pga_bypassed,
   output logic      [1:0]  ref_sel,
   output logic             temp_sensor_mode,
   output logic             midsupply_short,
   output logic      [10:0] excitation_current_ua,
   output logic             excitation_on,
   output logic             excitation_valid,
   output logic      [2:0]  source1_route_sel,
   output logic      [2:0]  source2_route_sel,
   output logic             low_side_switch_closed,
   output logic             burnout_source_on,
   output logic      [3:0]  burnout_current_ua
);
   logic [7:0]     cfg0;
   logic [7:0]     cfg1;
   logic [7:0]     cfg2;
   logic [7:0]     cfg3;
   logic [7:0]     next_cfg0;
   logic [7:0]     next_cfg1;
   logic [7:0]     next_cfg2;
   logic [7:0]     next_cfg3;
   aafc_state_type state;
   aafc_state_type next_state;
   logic           sleep_pending;
   logic           next_sleep_pending;
   logic           single_only;
   logic           next_single_only;
   logic           switch_closed;
   logic           next_switch_closed;
   logic [15:0]    result;
   logic [15:0]    next_result;
   logic           next_conv_start;
   logic [31:0]    next_prdata;

   logic           wr_access;
   logic           rd_setup;
   logic           mapped;
   logic           cfg_write;
   logic           start_req;
   logic           sleep_req;
   logic           idac_write;

   aafc_timer_if   tmr ();

   // magnitude table; code 7 is unused and reads as off
   function automatic aafc_ua_type idac_ua(input logic [2:0] code);
      unique case (code)
         3'h1:    idac_ua = `AAFC_IDAC_50_UA;
         3'h2:    idac_ua = `AAFC_IDAC_100_UA;
         3'h3:    idac_ua = `AAFC_IDAC_250_UA;
         3'h4:    idac_ua = `AAFC_IDAC_500_UA;
         3'h5:    idac_ua = `AAFC_IDAC_1000_UA;
         3'h6:    idac_ua = `AAFC_IDAC_1500_UA;
         default: idac_ua = 11'h000;
      endcase
   endfunction : idac_ua

   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == `AAFC_CFG0_ADDR) || (a == `AAFC_CFG1_ADDR) ||
                 (a == `AAFC_CFG2_ADDR) || (a == `AAFC_CFG3_ADDR) ||
                 (a == `AAFC_CMD_ADDR) || (a == `AAFC_STATUS_ADDR) ||
                 (a == `AAFC_RESULT_ADDR);
   endfunction : addr_hit

   // ---------------- apb slave ----------------
   // zero wait states: read data is captured in the setup cycle
   assign mapped    = addr_hit(paddr);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;
   assign wr_access = psel && penable && pwrite && mapped;
   assign rd_setup  = psel && !penable && !pwrite;

   assign cfg_write  = wr_access && (paddr <= `AAFC_CFG3_ADDR);
   assign idac_write = wr_access && (paddr == `AAFC_CFG2_ADDR) &&
                       (pwdata[`AAFC_CFG2_IDAC_MSB:`AAFC_CFG2_IDAC_LSB] !=
                        cfg2[`AAFC_CFG2_IDAC_MSB:`AAFC_CFG2_IDAC_LSB]);
   assign sleep_req  = wr_access && (paddr == `AAFC_CMD_ADDR) &&
                       pwdata[`AAFC_CMD_SLEEP];
   // any config write restarts a conversion; sleep wins over start
   assign start_req  = !sleep_req && (cfg_write ||
                       (wr_access && (paddr == `AAFC_CMD_ADDR) &&
                        pwdata[`AAFC_CMD_START]));

   always_comb begin
      next_cfg0 = cfg0;
      next_cfg1 = cfg1;
      next_cfg2 = cfg2;
      next_cfg3 = cfg3;
      if (wr_access) begin
         unique case (paddr)
            `AAFC_CFG0_ADDR: next_cfg0 = pwdata[7:0];
            `AAFC_CFG1_ADDR: next_cfg1 = {5'h00, pwdata[2:0]};
            `AAFC_CFG2_ADDR: next_cfg2 = {pwdata[7:6], 2'h0, pwdata[3:0]};
            `AAFC_CFG3_ADDR: next_cfg3 = {pwdata[7:2], 2'h0};
            default:         next_cfg0 = cfg0;
         endcase
      end
   end

   always_comb begin
      next_prdata = prdata;
      if (rd_setup) begin
         unique case (paddr)
            `AAFC_CFG0_ADDR:   next_prdata = {24'h00_0000, cfg0};
            `AAFC_CFG1_ADDR:   next_prdata = {24'h00_0000, cfg1};
            `AAFC_CFG2_ADDR:   next_prdata = {24'h00_0000, cfg2};
            `AAFC_CFG3_ADDR:   next_prdata = {24'h00_0000, cfg3};
            `AAFC_STATUS_ADDR: next_prdata = {27'h000_0000, excitation_valid,
                                              switch_closed, sleep_pending,
                                              state == aafc_sleep,
                                              state == aafc_conv};
            `AAFC_RESULT_ADDR: next_prdata = {16'h0000, result};
            default:           next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg0   <= `AAFC_CFG_RESET;
         cfg1   <= `AAFC_CFG_RESET;
         cfg2   <= `AAFC_CFG_RESET;
         cfg3   <= `AAFC_CFG_RESET;
         prdata <= 32'h0000_0000;
      end else begin
         cfg0   <= next_cfg0;
         cfg1   <= next_cfg1;
         cfg2   <= next_cfg2;
         cfg3   <= next_cfg3;
         prdata <= next_prdata;
      end
   end

   // ---------------- conversion sequencing ----------------
   always_comb begin
      next_state         = state;
      next_sleep_pending = sleep_pending;
      next_single_only   = single_only;
      next_result        = result;
      next_conv_start    = 1'b0;
      unique case (state)
         aafc_idle: begin
            if (start_req) begin
               next_state       = aafc_conv;
               next_conv_start  = 1'b1;
               next_single_only = cfg_write;
            end else if (sleep_req) begin
               next_state = aafc_sleep;
            end
         end
         aafc_conv: begin
            if (start_req) begin
               next_conv_start    = 1'b1;
               next_single_only   = cfg_write;
               next_sleep_pending = 1'b0;
            end else if (conv_done) begin
               // temperature word is 14 bits left-justified
               next_result = temp_sensor_mode ? {temp_code, 2'b00} : conv_code;
               if (sleep_pending || sleep_req) begin
                  next_state         = aafc_sleep;
                  next_sleep_pending = 1'b0;
               end else if (cfg1[`AAFC_CFG1_CONT] && !single_only) begin
                  next_conv_start = 1'b1;
               end else begin
                  next_state = aafc_idle;
               end
            end else if (sleep_req) begin
               next_sleep_pending = 1'b1;
            end
         end
         aafc_sleep: begin
            // config write wakes for one conversion only
            if (start_req) begin
               next_state       = aafc_conv;
               next_conv_start  = 1'b1;
               next_single_only = cfg_write;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= aafc_idle;
         sleep_pending <= 1'b0;
         single_only   <= 1'b0;
         result        <= 16'h0000;
         conv_start    <= 1'b0;
      end else begin
         state         <= next_state;
         sleep_pending <= next_sleep_pending;
         single_only   <= next_single_only;
         result        <= next_result;
         conv_start    <= next_conv_start;
      end
   end

   // ---------------- low-side switch ----------------
   always_comb begin
      next_switch_closed = switch_closed;
      if (start_req) begin
         next_switch_closed = 1'b1;
      end
      if (next_state == aafc_sleep) begin
         next_switch_closed = 1'b0;
      end
      if (!next_cfg2[`AAFC_CFG2_PSW]) begin
         next_switch_closed = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_closed <= 1'b0;
      end else begin
         switch_closed <= next_switch_closed;
      end
   end

   assign low_side_switch_closed = switch_closed;

   // ---------------- excitation sources ----------------
   // restart the settle wait on a new magnitude or on wake-up
   assign tmr.restart = idac_write ||
                        (state == aafc_sleep && next_state != aafc_sleep);

   aafc_startup_timer #(
      .CYCLES (IDAC_START_CYCLES)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .tmr     (tmr.timer)
   );

   // ---------------- effective front-end settings ----------------
   logic        mon_code;
   logic        force_int_ref;
   logic [3:0]  mux_raw;
   logic [3:0]  next_input_select;
   logic [2:0]  next_gain_sel;
   logic        next_pga_bypassed;
   logic [1:0]  next_ref_sel;
   logic        next_excitation_on;
   logic        next_burnout_on;

   assign mux_raw = cfg0[`AAFC_CFG0_MUX_MSB:`AAFC_CFG0_MUX_LSB];

   always_comb begin
      next_input_select = cfg1[`AAFC_CFG1_TEMP] ? 4'h0 : mux_raw;
      // same-cycle view of the temperature bit keeps all settings in step
      mon_code = !cfg1[`AAFC_CFG1_TEMP] && ((mux_raw == `AAFC_MUX_REF_MON) ||
                                            (mux_raw == `AAFC_MUX_SUPPLY_MON) ||
                                            (mux_raw == `AAFC_MUX_SHORTED));
      force_int_ref = cfg1[`AAFC_CFG1_TEMP] ||
                      (!cfg1[`AAFC_CFG1_TEMP] &&
                       ((mux_raw == `AAFC_MUX_REF_MON) ||
                        (mux_raw == `AAFC_MUX_SUPPLY_MON)));
      next_gain_sel     = cfg0[`AAFC_CFG0_GAIN_MSB:`AAFC_CFG0_GAIN_LSB];
      next_pga_bypassed = cfg0[`AAFC_CFG0_BYPASS];
      if (mon_code) begin
         next_gain_sel     = `AAFC_GAIN_ONE;
         next_pga_bypassed = 1'b1;
      end
      next_ref_sel = force_int_ref ? `AAFC_REF_INTERNAL :
                     cfg2[`AAFC_CFG2_REF_MSB:`AAFC_CFG2_REF_LSB];
      // sources stay up between single conversions
      next_excitation_on = (idac_ua(cfg2[`AAFC_CFG2_IDAC_MSB:`AAFC_CFG2_IDAC_LSB]) != 11'h000) &&
                           (next_state != aafc_sleep);
      next_burnout_on = cfg1[`AAFC_CFG1_BURNOUT] && (next_state != aafc_sleep);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_select          <= 4'h0;
         gain_sel              <= 3'h0;
         pga_bypassed          <= 1'b0;
         ref_sel               <= 2'h0;
         temp_sensor_mode      <= 1'b0;
         midsupply_short       <= 1'b0;
         excitation_current_ua <= 11'h000;
         excitation_on         <= 1'b0;
         source1_route_sel     <= 3'h0;
         source2_route_sel     <= 3'h0;
         burnout_source_on     <= 1'b0;
      end else begin
         input_select          <= next_input_select;
         gain_sel              <= next_gain_sel;
         pga_bypassed          <= next_pga_bypassed;
         ref_sel               <= next_ref_sel;
         temp_sensor_mode      <= cfg1[`AAFC_CFG1_TEMP];
         midsupply_short       <= !cfg1[`AAFC_CFG1_TEMP] &&
                                  (mux_raw == `AAFC_MUX_SHORTED);
         excitation_current_ua <= idac_ua(cfg2[`AAFC_CFG2_IDAC_MSB:`AAFC_CFG2_IDAC_LSB]);
         excitation_on         <= next_excitation_on;
         source1_route_sel     <= cfg3[`AAFC_CFG3_R1_MSB:`AAFC_CFG3_R1_LSB];
         source2_route_sel     <= cfg3[`AAFC_CFG3_R2_MSB:`AAFC_CFG3_R2_LSB];
         burnout_source_on     <= next_burnout_on;
      end
   end

   assign excitation_valid   = excitation_on && tmr.ready;
   assign burnout_current_ua = burnout_source_on ? `AAFC_BURNOUT_UA : 4'h0;
   assign conv_active        = (state == aafc_conv);
endmodule : aafc_frontend

//--- src/aafc_params.svh
`ifndef AAFC_PARAMS_SVH
`define AAFC_PARAMS_SVH

`define AAFC_CLK_PERIOD_NS     20
`define AAFC_IDAC_START_NS     200000
`define AAFC_IDAC_START_CYCLES \
   ((`AAFC_IDAC_START_NS + `AAFC_CLK_PERIOD_NS - 1) / `AAFC_CLK_PERIOD_NS)

`define AAFC_CFG0_ADDR         8'h00
`define AAFC_CFG1_ADDR         8'h04
`define AAFC_CFG2_ADDR         8'h08
`define AAFC_CFG3_ADDR         8'h0C
`define AAFC_CMD_ADDR          8'h10
`define AAFC_STATUS_ADDR       8'h14
`define AAFC_RESULT_ADDR       8'h18

`define AAFC_CFG_RESET         8'h00

`define AAFC_CFG0_MUX_MSB      7
`define AAFC_CFG0_MUX_LSB      4
`define AAFC_CFG0_GAIN_MSB     3
`define AAFC_CFG0_GAIN_LSB     1
`define AAFC_CFG0_BYPASS       0
`define AAFC_CFG1_CONT         2
`define AAFC_CFG1_TEMP         1
`define AAFC_CFG1_BURNOUT      0
`define AAFC_CFG2_REF_MSB      7
`define AAFC_CFG2_REF_LSB      6
`define AAFC_CFG2_PSW          3
`define AAFC_CFG2_IDAC_MSB     2
`define AAFC_CFG2_IDAC_LSB     0
`define AAFC_CFG3_R1_MSB       7
`define AAFC_CFG3_R1_LSB       5
`define AAFC_CFG3_R2_MSB       4
`define AAFC_CFG3_R2_LSB       2
`define AAFC_CMD_START         0
`define AAFC_CMD_SLEEP         1

`define AAFC_MUX_REF_MON       4'hC
`define AAFC_MUX_SUPPLY_MON    4'hD
`define AAFC_MUX_SHORTED       4'hE
`define AAFC_GAIN_ONE          3'h0
`define AAFC_REF_INTERNAL      2'h0

`define AAFC_IDAC_OFF          3'h0
`define AAFC_IDAC_50_UA        11'h032
`define AAFC_IDAC_100_UA       11'h064
`define AAFC_IDAC_250_UA       11'h0FA
`define AAFC_IDAC_500_UA       11'h1F4
`define AAFC_IDAC_1000_UA      11'h3E8
`define AAFC_IDAC_1500_UA      11'h5DC
`define AAFC_BURNOUT_UA        4'hA

`endif

//--- src/aafc_pkg.sv
package aafc_pkg;
   typedef enum logic [1:0] {
      aafc_idle,
      aafc_conv,
      aafc_sleep
   } aafc_state_type;

   typedef logic [10:0] aafc_ua_type;
endpackage : aafc_pkg

//--- src/aafc_startup_timer.sv
`include "aafc_params.svh"

module aafc_startup_timer #(
   parameter int unsigned CYCLES = `AAFC_IDAC_START_CYCLES
) (
   input  wire logic   pclk,
   input  wire logic   presetn,
   aafc_timer_if.timer tmr
);
   // wide enough for the default; a shortened value only fits better
   logic [13:0] count;
   logic [13:0] next_count;
   logic        ready;
   logic        next_ready;

   localparam logic [13:0] LAST = 14'(CYCLES - 1);

   always_comb begin
      next_count = count;
      next_ready = ready;
      if (tmr.restart) begin
         next_count = '0;
         next_ready = 1'b0;
      end else if (!ready) begin
         if (count == LAST) begin
            next_ready = 1'b1;
         end else begin
            next_count = count + 14'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 14'h0000;
         ready <= 1'b0;
      end else begin
         count <= next_count;
         ready <= next_ready;
      end
   end

   assign tmr.ready = ready;
endmodule : aafc_startup_timer

//--- src/aafc_timer_if.sv
interface aafc_timer_if;
   logic restart;
   logic ready;

   modport ctrl  (output restart, input ready);
   modport timer (input restart, output ready);
endinterface : aafc_timer_if

//--- test/aafc_conv_model.sv
module aafc_conv_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        conv_start,
   input  wire logic [7:0]  conv_len,
   input  wire logic [15:0] word_in,
   input  wire logic [13:0] temp_in,
   output logic             conv_done,
   output logic      [15:0] conv_code,
   output logic      [13:0] temp_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left;
   // results toggle outside the done pulse so a late sample cannot match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left <= 8'h00;
         conv_done <= 1'b0;
         conv_code <= 16'h0000;
         temp_code <= 14'h0000;
      end else begin
         conv_done <= 1'b0;
         conv_code <= ~conv_code;
         temp_code <= ~temp_code;
         if (conv_start) left <= conv_len;
         else if (left == 8'h01) begin
            left <= 8'h00;
            conv_done <= 1'b1;
            conv_code <= word_in;
            temp_code <= temp_in;
         end else if (left != 8'h00) left <= left - 8'h01;
      end
   end
endmodule : aafc_conv_model

//--- test/aafc_properties.sv
module aafc_properties #(
   parameter int unsigned IDAC_START_CYCLES = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        conv_done,
   input wire logic        conv_start,
   input wire logic        conv_active,
   input wire logic [3:0]  input_select,
   input wire logic [2:0]  gain_sel,
   input wire logic        pga_bypassed,
   input wire logic [1:0]  ref_sel,
   input wire logic        temp_sensor_mode,
   input wire logic        midsupply_short,
   input wire logic [10:0] excitation_current_ua,
   input wire logic        excitation_on,
   input wire logic        excitation_valid,
   input wire logic        low_side_switch_closed,
   input wire logic        burnout_source_on,
   input wire logic [3:0]  burnout_current_ua
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wr;
   logic [15:0] on_cnt;
   logic [15:0] next_on_cnt;
   logic [10:0] prev_ua;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr = psel && penable && pwrite;
   // cycles the magnitude has stood unchanged while on
   always_comb begin
      if (!excitation_on || excitation_current_ua != prev_ua) next_on_cnt = 16'h0000;
      else if (on_cnt == 16'hFFFF) next_on_cnt = on_cnt;
      else next_on_cnt = on_cnt + 16'h0001;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_cnt <= 16'h0000;
         prev_ua <= 11'h000;
      end else begin
         on_cnt <= next_on_cnt;
         prev_ua <= excitation_current_ua;
      end
   end
   sequence s_start_wr;
      wr && paddr == 8'h10 && pwdata[1:0] == 2'b01;
   endsequence
   sequence s_sleep_wr;
      wr && paddr == 8'h10 && pwdata[1];
   endsequence
   a_start_pulse: assert property (s_start_wr |=> conv_start && conv_active)
      else $error("start gave no pulse");
   a_sleep_waits: assert property (s_sleep_wr ##0 (conv_active && !conv_done) |=> conv_active)
      else $error("sleep cut a conversion short");
   a_sleep_off: assert property (s_sleep_wr ##0 !conv_active
      |-> ##[1:3] (!excitation_on && !low_side_switch_closed)) else $error("sleep left power on");
   a_sw_clear: assert property (wr && paddr == 8'h08 && !pwdata[3] |=> !low_side_switch_closed)
      else $error("switch not opened");
   a_sw_close: assert property ($rose(low_side_switch_closed) |-> conv_start || $past(conv_start))
      else $error("switch closed without start");
   a_monitor_gain: assert property (input_select inside {4'hC, 4'hD, 4'hE}
      |-> gain_sel == 3'h0 && pga_bypassed) else $error("monitor gain not forced");
   a_monitor_ref: assert property (input_select inside {4'hC, 4'hD} || temp_sensor_mode
      |-> ref_sel == 2'h0) else $error("monitor reference not internal");
   a_short_match: assert property (midsupply_short == (input_select == 4'hE))
      else $error("short flag wrong");
   a_temp_ignore: assert property (temp_sensor_mode |-> input_select == 4'h0)
      else $error("temperature mode used config 0");
   a_idac_legal: assert property (excitation_on |-> excitation_current_ua inside
      {11'h032, 11'h064, 11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC}) else $error("bad magnitude");
   a_valid_early: assert property (excitation_valid |-> excitation_on && on_cnt + 3 >= IDAC_START_CYCLES)
      else $error("sources valid too soon");
   a_valid_late: assert property (on_cnt == IDAC_START_CYCLES + 3 |-> excitation_valid)
      else $error("sources never valid");
   a_burnout_amp: assert property (burnout_current_ua == (burnout_source_on ? 4'hA : 4'h0))
      else $error("burn-out current wrong");
endmodule : aafc_properties

bind aafc_frontend aafc_properties #(.IDAC_START_CYCLES(IDAC_START_CYCLES)) u_props (.*);

//--- test/tb_adc_aux_frontend_control.sv
module tb_adc_aux_frontend_control;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
   typedef struct packed {
      logic [7:0] c0; logic [7:0] c2; logic [3:0] sel; logic [2:0] gain;
      logic byp; logic [1:0] rs; logic sh; logic [10:0] ua;
   } aafc_row_type;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, conv_len = 8'h1E;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
   logic [15:0] conv_code, word_in = 16'h1234;
   logic [13:0] temp_code, temp_in = 14'h3B00;
   logic pready, pslverr, rerr, conv_done, conv_start, conv_active, pga_bypassed;
   logic temp_sensor_mode, midsupply_short, excitation_on, excitation_valid;
   logic low_side_switch_closed, burnout_source_on;
   logic [3:0] input_select, burnout_current_ua;
   logic [2:0] gain_sel, source1_route_sel, source2_route_sel;
   logic [1:0] ref_sel;
   logic [10:0] excitation_current_ua;
   aafc_row_type rows[8];
   logic [13:0] tcode[3] = '{14'h3B00, 14'h1000, 14'h0000};
   logic [31:0] rexp[3] = '{32'h0000_EC00, 32'h0000_4000, 32'h0000_1234};
   int tests_run = 0, miscompares = 0, n;

   aafc_frontend #(.IDAC_START_CYCLES(20)) uut (.*);
   aafc_conv_model partner (.*);
   always #10 pclk = ~pclk;

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) miscompares++;
   endtask : apb

   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask : tick

   task automatic wait_idle;
      int k;
      tick(2);
      for (k = 0; conv_active !== 1'b0 && k < 500; k++) @(posedge pclk);
      if (k >= 500) miscompares++;
      tick(2);
   endtask : wait_idle

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      summarize();
   end

   initial begin
      rows[0] = {8'h3B, 8'h80, 4'h3, 3'h5, 1'b1, 2'h2, 1'b0, 11'h000};
      rows[1] = {8'hC6, 8'h81, 4'hC, 3'h0, 1'b1, 2'h0, 1'b0, 11'h032};
      rows[2] = {8'hD2, 8'h82, 4'hD, 3'h0, 1'b1, 2'h0, 1'b0, 11'h064};
      rows[3] = {8'hE4, 8'h83, 4'hE, 3'h0, 1'b1, 2'h2, 1'b1, 11'h0FA};
      rows[4] = {8'h0A, 8'h44, 4'h0, 3'h5, 1'b0, 2'h1, 1'b0, 11'h1F4};
      rows[5] = {8'h71, 8'h05, 4'h7, 3'h0, 1'b1, 2'h0, 1'b0, 11'h3E8};
      rows[6] = {8'h5E, 8'hC6, 4'h5, 3'h7, 1'b0, 2'h3, 1'b0, 11'h5DC};
      rows[7] = {8'h20, 8'h07, 4'h2, 3'h0, 1'b0, 2'h0, 1'b0, 11'h000};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      `CHK("switch_rst", 1'b0, low_side_switch_closed)
      `CHK("idac_rst", 1'b0, excitation_on)
      foreach (rows[i]) begin
         apb(1'b1, 8'h00, {24'h00_0000, rows[i].c0});
         apb(1'b1, 8'h08, {24'h00_0000, rows[i].c2});
         tick(3);
         `CHK("sel", rows[i].sel, input_select)
         `CHK("gain", rows[i].gain, gain_sel)
         `CHK("bypass", rows[i].byp, pga_bypassed)
         `CHK("ref", rows[i].rs, ref_sel)
         `CHK("short", rows[i].sh, midsupply_short)
         `CHK("ua", rows[i].ua, excitation_current_ua)
         `CHK("on", rows[i].ua != 11'h000, excitation_on)
      end
      apb(1'b1, 8'h08, 32'h0000_0080);
      apb(1'b1, 8'h00, 32'h0000_00C5);
      apb(1'b1, 8'h04, 32'h0000_0002);
      tick(3);
      `CHK("ts_view", 7'h40, {temp_sensor_mode, ref_sel, input_select})
      for (int k = 0; k < 3; k++) begin
         temp_in <= tcode[k];
         if (k == 2) apb(1'b1, 8'h04, 32'h0000_0000);
         apb(1'b1, 8'h10, 32'h0000_0001);
         wait_idle();
         apb(1'b0, 8'h18, 32'h0000_0000);
         `CHK("result", rexp[k], rdata)
      end
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'h0000_000B);
      for (n = 0; excitation_valid !== 1'b1 && n < 100; n++) @(posedge pclk);
      `CHK("idac_wait", 1'b1, n >= 17 && n <= 24)
      `CHK("sw_close", 1'b1, low_side_switch_closed)
      wait_idle();
      `CHK("between", 2'b11, {low_side_switch_closed, excitation_on})
      apb(1'b1, 8'h10, 32'h0000_0002);
      tick(1);
      `CHK("idle_sleep", 2'b00, {low_side_switch_closed, excitation_on})
      apb(1'b1, 8'h10, 32'h0000_0001);
      tick(3);
      apb(1'b1, 8'h10, 32'h0000_0002);
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK("pending", 3'b101, rdata[2:0])
      wait_idle();
      `CHK("asleep", 2'b00, {low_side_switch_closed, excitation_on})
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK("status", 2'b10, rdata[1:0])
      apb(1'b1, 8'h10, 32'h0000_0001);
      tick(3);
      `CHK("wake", 3'b110, {low_side_switch_closed, excitation_on, excitation_valid})
      apb(1'b1, 8'h08, 32'h0000_0003);
      #1;
      `CHK("sw_clear", 1'b0, low_side_switch_closed)
      // magnitude is already set, so routing goes last
      apb(1'b1, 8'h0C, 32'h0000_00B4);
      tick(3);
      `CHK("route_same", 6'h2D, {source1_route_sel, source2_route_sel})
      apb(1'b1, 8'h0C, 32'h0000_0078);
      tick(3);
      `CHK("route_split", 6'h1E, {source1_route_sel, source2_route_sel})
      apb(1'b1, 8'h04, 32'h0000_0001);
      tick(3);
      `CHK("burnout_on", 5'h1A, {burnout_source_on, burnout_current_ua})
      apb(1'b1, 8'h04, 32'h0000_0000);
      tick(3);
      `CHK("burnout_off", 5'h00, {burnout_source_on, burnout_current_ua})
      apb(1'b1, 8'h04, 32'h0000_0004);
      apb(1'b1, 8'h10, 32'h0000_0001);
      tick(70);
      `CHK("continuous", 1'b1, conv_active)
      apb(1'b1, 8'h10, 32'h0000_0002);
      wait_idle();
      `CHK("cont_stop", 1'b0, conv_active)
      apb(1'b0, 8'h1C, 32'h0000_0000);
      `CHK("unmapped", 33'h1_0000_0000, {rerr, rdata})
      summarize();
   end
endmodule : tb_adc_aux_frontend_control
